// ==== hw/dspdec_cfg.svh ====
// dspdec_cfg.svh: opcode patterns, field positions, register map and reset values
// assumes inclusion by the decoder module only
`ifndef DSPDEC_CFG_SVH
`define DSPDEC_CFG_SVH

// full 16-bit instruction words
`define DD_W_JUMP        16'hF900
`define DD_W_CALL_ACC    16'h7F8C
`define DD_W_CALL        16'hF800
`define DD_W_RETURN      16'h7F8D
`define DD_W_IRQ_MASK    16'h7F81
`define DD_W_IRQ_UNMASK  16'h7F82
`define DD_W_POP         16'h7F9D
`define DD_W_PUSH        16'h7F9C
`define DD_W_ADD_PROD    16'h7F8F

// upper bytes
`define DD_B_AUX_NZ      8'hF4
`define DD_B_OVF         8'hF5
`define DD_B_TEST_LOW    8'hF6
`define DD_B_ACC_LT      8'hFA
`define DD_B_ACC_LE      8'hFB
`define DD_B_ACC_GT      8'hFC
`define DD_B_ACC_GE      8'hFD
`define DD_B_ACC_NZ      8'hFE
`define DD_B_ACC_Z       8'hFF
`define DD_B_LOAD_ST     8'h7B
`define DD_B_DATA_COPY   8'h69
`define DD_B_LOAD_T_MOVE 8'h6B
`define DD_B_PAGE_LOAD   8'h6F
`define DD_B_AUX_MODIFY  8'h68

// partial patterns: top bits only
`define DD_P_PORT_IN     5'h08
`define DD_P_PORT_OUT    5'h09
`define DD_P_AUX_IMM     7'h38
`define DD_P_AUX_STORE   7'h18
`define DD_P_ARP_IMM     15'h3440
`define DD_P_PAGE_IMM    15'h3700

// operand fields
`define DD_F_IND_BIT     7
`define DD_F_ARP_KEEP    3
`define DD_F_R_BIT       8
`define DD_F_K_BIT       0
`define DD_F_PORT_LSB    8
`define DD_TARGET_W      12

// register map, byte addresses
`define DD_A_CTRL        8'h00
`define DD_A_STATUS      8'h04
`define DD_A_LAST_OP     8'h08
`define DD_A_COUNT       8'h0C

// reset values
`define DD_RST_ENABLE    1'b1
`define DD_RST_IRQ_MASK  1'b1
`define DD_RST_ARP       1'b0
`define DD_RST_PAGE      1'b0

`endif

// ==== hw/dspdec_pkg.sv ====
// dspdec_pkg: decoded operation and sequencer state types
// assumes dspdec_cfg.svh holds every numeric constant
package dspdec_pkg;

  typedef enum logic [4:0] {
    DD_OP_OTHER,
    DD_OP_JUMP,
    DD_OP_JUMP_AUX_NONZERO,
    DD_OP_JUMP_ACC_GE_ZERO,
    DD_OP_JUMP_ACC_GT_ZERO,
    DD_OP_JUMP_ACC_LE_ZERO,
    DD_OP_JUMP_ACC_LT_ZERO,
    DD_OP_JUMP_ACC_NONZERO,
    DD_OP_JUMP_ACC_ZERO,
    DD_OP_JUMP_TEST_PIN_LOW,
    DD_OP_JUMP_ON_OVF,
    DD_OP_CALL_FROM_ACC,
    DD_OP_CALL_DIRECT,
    DD_OP_RETURN_SUB,
    DD_OP_IRQ_MASK,
    DD_OP_IRQ_UNMASK,
    DD_OP_LOAD_STATUS_WORD,
    DD_OP_STACK_POP,
    DD_OP_STACK_PUSH,
    DD_OP_DATA_SHIFT_COPY,
    DD_OP_PORT_IN,
    DD_OP_PORT_OUT,
    DD_OP_ADD_PRODUCT,
    DD_OP_LOAD_T_ACC_MOVE,
    DD_OP_AUX_LOAD_IMM,
    DD_OP_AUX_PTR_LOAD_IMM,
    DD_OP_PAGE_PTR_LOAD,
    DD_OP_PAGE_PTR_LOAD_IMM,
    DD_OP_AUX_MODIFY,
    DD_OP_AUX_STORE
  } dspdec_op_e;

  typedef enum logic [1:0] {
    DD_ST_IDLE,
    DD_ST_WORD2,
    DD_ST_STALL
  } dspdec_state_e;

endpackage : dspdec_pkg

// ==== hw/dspdec_decoder.sv ====
// dspdec_decoder: instruction decoder and cycle sequencer with a wishbone register port
// assumes one clock domain shared with fetch and datapath; test_pin is asynchronous
//
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "dspdec_cfg.svh"

module dspdec_decoder
  import dspdec_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  output logic             instr_ready,
  input  wire logic        acc_zero,
  input  wire logic        acc_neg,
  input  wire logic        aux_nonzero,
  input  wire logic        ovf_flag,
  input  wire logic        test_pin,
  input  wire logic        page_load_bit,
  output logic             op_valid,
  output dspdec_op_e       op_code,
  output logic             op_taken,
  output logic      [11:0] op_target,
  output logic      [6:0]  op_dma,
  output logic             op_indirect,
  output logic      [7:0]  op_operand,
  output logic             op_aux_sel,
  output logic      [2:0]  op_port,
  output logic             aux_select_pointer,
  output logic             page_pointer,
  output logic             irq_masked,
  output logic             busy
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // opcode classification, one pattern per instruction
  function automatic dspdec_op_e classify(input logic [15:0] w);
    dspdec_op_e r;
    r = DD_OP_OTHER;
    if (w == `DD_W_JUMP) r = DD_OP_JUMP;
    else if (w == `DD_W_CALL) r = DD_OP_CALL_DIRECT;
    else if (w == `DD_W_CALL_ACC) r = DD_OP_CALL_FROM_ACC;
    else if (w == `DD_W_RETURN) r = DD_OP_RETURN_SUB;
    else if (w == `DD_W_IRQ_MASK) r = DD_OP_IRQ_MASK;
    else if (w == `DD_W_IRQ_UNMASK) r = DD_OP_IRQ_UNMASK;
    else if (w == `DD_W_POP) r = DD_OP_STACK_POP;
    else if (w == `DD_W_PUSH) r = DD_OP_STACK_PUSH;
    else if (w == `DD_W_ADD_PROD) r = DD_OP_ADD_PRODUCT;
    else if (w[15:1] == `DD_P_ARP_IMM) r = DD_OP_AUX_PTR_LOAD_IMM;
    else if (w[15:1] == `DD_P_PAGE_IMM) r = DD_OP_PAGE_PTR_LOAD_IMM;
    else if (w[15:11] == `DD_P_PORT_IN) r = DD_OP_PORT_IN;
    else if (w[15:11] == `DD_P_PORT_OUT) r = DD_OP_PORT_OUT;
    else if (w[15:9] == `DD_P_AUX_IMM) r = DD_OP_AUX_LOAD_IMM;
    else if (w[15:9] == `DD_P_AUX_STORE) r = DD_OP_AUX_STORE;
    else
    begin
      unique case (w[15:8])
        `DD_B_AUX_NZ:      r = DD_OP_JUMP_AUX_NONZERO;
        `DD_B_ACC_GE:      r = DD_OP_JUMP_ACC_GE_ZERO;
        `DD_B_ACC_GT:      r = DD_OP_JUMP_ACC_GT_ZERO;
        `DD_B_ACC_LE:      r = DD_OP_JUMP_ACC_LE_ZERO;
        `DD_B_ACC_LT:      r = DD_OP_JUMP_ACC_LT_ZERO;
        `DD_B_ACC_NZ:      r = DD_OP_JUMP_ACC_NONZERO;
        `DD_B_ACC_Z:       r = DD_OP_JUMP_ACC_ZERO;
        `DD_B_TEST_LOW:    r = DD_OP_JUMP_TEST_PIN_LOW;
        `DD_B_OVF:         r = DD_OP_JUMP_ON_OVF;
        `DD_B_LOAD_ST:     r = DD_OP_LOAD_STATUS_WORD;
        `DD_B_DATA_COPY:   r = DD_OP_DATA_SHIFT_COPY;
        `DD_B_LOAD_T_MOVE: r = DD_OP_LOAD_T_ACC_MOVE;
        `DD_B_PAGE_LOAD:   r = DD_OP_PAGE_PTR_LOAD;
        `DD_B_AUX_MODIFY:  r = DD_OP_AUX_MODIFY;
        default:           r = DD_OP_OTHER;
      endcase
    end
    return r;
  endfunction : classify

  // two-word instructions carry a target in the second word
  function automatic logic is_two_word(input dspdec_op_e op);
    return (op inside {DD_OP_JUMP, DD_OP_JUMP_AUX_NONZERO, DD_OP_JUMP_ACC_GE_ZERO,
                       DD_OP_JUMP_ACC_GT_ZERO, DD_OP_JUMP_ACC_LE_ZERO, DD_OP_JUMP_ACC_LT_ZERO,
                       DD_OP_JUMP_ACC_NONZERO, DD_OP_JUMP_ACC_ZERO, DD_OP_JUMP_TEST_PIN_LOW,
                       DD_OP_JUMP_ON_OVF, DD_OP_CALL_DIRECT});
  endfunction : is_two_word

  // one-word instructions that still need a second cycle
  function automatic logic is_stall(input dspdec_op_e op);
    return (op inside {DD_OP_CALL_FROM_ACC, DD_OP_RETURN_SUB, DD_OP_STACK_POP,
                       DD_OP_STACK_PUSH, DD_OP_PORT_IN, DD_OP_PORT_OUT});
  endfunction : is_stall

  ////////////////////////////////////////////////////////////////////////////
  // test pin synchroniser, only the second stage is read

  logic test_meta_ff;
  logic test_sync_ff;

  always_ff @(posedge clock)
  begin
    test_meta_ff <= test_pin;
    test_sync_ff <= test_meta_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  dspdec_state_e state_ff;
  dspdec_state_e nxt_state;
  dspdec_op_e    held_op_ff;
  logic [15:0]   first_ff;
  logic          ctrl_en_ff;

  wire logic       in_idle   = (state_ff == DD_ST_IDLE);
  wire logic       in_word2  = (state_ff == DD_ST_WORD2);
  wire logic       in_stall  = (state_ff == DD_ST_STALL);
  wire logic       take      = instr_valid && instr_ready;
  wire dspdec_op_e word_op   = classify(instr_word);
  wire logic       take_two  = take && in_idle && is_two_word(word_op);
  wire logic       take_stl  = take && in_idle && is_stall(word_op);
  wire logic       take_one  = take && in_idle && !is_two_word(word_op) && !is_stall(word_op);
  // completion in the cycle that ends the listed cycle count
  wire logic       done_now  = take_one || (take && in_word2) || in_stall;
  wire dspdec_op_e done_op   = in_idle ? word_op : held_op_ff;
  wire logic [15:0] done_w   = in_idle ? instr_word : first_ff;
  wire logic       test_low  = !test_sync_ff;

  // fetch is refused in the stall cycle and while disabled between instructions
  assign instr_ready = (in_idle && ctrl_en_ff) || in_word2;
  assign busy        = !in_idle;

  // next state
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      DD_ST_IDLE:
      begin
        if (take_two)
          nxt_state = DD_ST_WORD2;
        else if (take_stl)
          nxt_state = DD_ST_STALL;
      end
      DD_ST_WORD2:
      begin
        if (take)
          nxt_state = DD_ST_IDLE;
      end
      DD_ST_STALL:
        nxt_state = DD_ST_IDLE;
    endcase
  end

  // branch condition of the held instruction at second-word time
  logic cond_met;
  always_comb
  begin
    unique case (held_op_ff)
      DD_OP_JUMP_AUX_NONZERO:  cond_met = aux_nonzero;
      DD_OP_JUMP_ACC_GE_ZERO:  cond_met = !acc_neg;
      DD_OP_JUMP_ACC_GT_ZERO:  cond_met = !acc_neg && !acc_zero;
      DD_OP_JUMP_ACC_LE_ZERO:  cond_met = acc_neg || acc_zero;
      DD_OP_JUMP_ACC_LT_ZERO:  cond_met = acc_neg;
      DD_OP_JUMP_ACC_NONZERO:  cond_met = !acc_zero;
      DD_OP_JUMP_ACC_ZERO:     cond_met = acc_zero;
      DD_OP_JUMP_TEST_PIN_LOW: cond_met = test_low;
      DD_OP_JUMP_ON_OVF:       cond_met = ovf_flag;
      default:                 cond_met = 1'b1;
    endcase
  end

  // state and first word
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_ff   <= DD_ST_IDLE;
      held_op_ff <= DD_OP_OTHER;
      first_ff   <= 16'h0000;
    end
    else
    begin
      state_ff <= nxt_state;
      if (take && in_idle)
      begin
        held_op_ff <= word_op;
        first_ff   <= instr_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded operation outputs, loaded at completion

  logic             op_valid_ff;
  dspdec_op_e       op_code_ff;
  logic             op_taken_ff;
  logic [11:0]      op_target_ff;
  logic [7:0]       op_operand_ff;
  logic [2:0]       op_port_ff;
  logic             op_aux_sel_ff;

  // target from the low 12 bits of the second word; the 0000 nibble is not checked
  wire logic [11:0] target_w = in_word2 ? instr_word[`DD_TARGET_W-1:0] : 12'h000;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      op_valid_ff   <= 1'b0;
      op_code_ff    <= DD_OP_OTHER;
      op_taken_ff   <= 1'b0;
      op_target_ff  <= 12'h000;
      op_operand_ff <= 8'h00;
      op_port_ff    <= 3'h0;
      op_aux_sel_ff <= 1'b0;
    end
    else
    begin
      op_valid_ff <= done_now;
      if (done_now)
      begin
        op_code_ff    <= done_op;
        op_taken_ff   <= in_word2 ? cond_met : 1'b0;
        op_target_ff  <= target_w;
        op_operand_ff <= done_w[7:0];
        op_port_ff    <= done_w[`DD_F_PORT_LSB+2:`DD_F_PORT_LSB];
        op_aux_sel_ff <= done_w[`DD_F_R_BIT];
      end
    end
  end

  assign op_valid    = op_valid_ff;
  assign op_code     = op_code_ff;
  assign op_taken    = op_taken_ff;
  assign op_target   = op_target_ff;
  assign op_operand  = op_operand_ff;
  assign op_port     = op_port_ff;
  assign op_aux_sel  = op_aux_sel_ff;
  // direct address is the low seven bits, 0 to 127
  assign op_dma      = op_operand_ff[6:0];
  assign op_indirect = op_operand_ff[`DD_F_IND_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // architectural pointers and interrupt mask kept by the decoder

  logic arp_ff;
  logic page_ff;
  logic irq_masked_ff;

  // indirect operands may name a new pointer when the keep bit is low
  wire logic ind_new_arp = done_w[`DD_F_IND_BIT] && !done_w[`DD_F_ARP_KEEP];
  wire logic has_mem_op  = !(done_op inside {DD_OP_OTHER, DD_OP_AUX_LOAD_IMM, DD_OP_AUX_PTR_LOAD_IMM,
                                             DD_OP_PAGE_PTR_LOAD_IMM, DD_OP_ADD_PRODUCT,
                                             DD_OP_IRQ_MASK, DD_OP_IRQ_UNMASK, DD_OP_STACK_POP,
                                             DD_OP_STACK_PUSH, DD_OP_RETURN_SUB, DD_OP_CALL_FROM_ACC})
                           && !is_two_word(done_op);

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      arp_ff        <= `DD_RST_ARP;
      page_ff       <= `DD_RST_PAGE;
      irq_masked_ff <= `DD_RST_IRQ_MASK;
    end
    else if (done_now)
    begin
      if (done_op == DD_OP_AUX_PTR_LOAD_IMM)
        arp_ff <= done_w[`DD_F_K_BIT];
      else if (has_mem_op && ind_new_arp)
        arp_ff <= done_w[`DD_F_K_BIT];
      if (done_op == DD_OP_PAGE_PTR_LOAD_IMM)
        page_ff <= done_w[`DD_F_K_BIT];
      else if (done_op == DD_OP_PAGE_PTR_LOAD)
        page_ff <= page_load_bit;
      if (done_op == DD_OP_IRQ_MASK)
        irq_masked_ff <= 1'b1;
      else if (done_op == DD_OP_IRQ_UNMASK)
        irq_masked_ff <= 1'b0;
    end
  end

  assign aux_select_pointer = arp_ff;
  assign page_pointer       = page_ff;
  assign irq_masked         = irq_masked_ff;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, unmapped reads return zero

  logic        ack_ff;
  logic [31:0] dat_ff;
  logic [15:0] count_ff;

  wire logic req       = wb_cyc_i && wb_stb_i && !ack_ff;
  wire logic wr_req    = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff; // write lands on the acked edge only
  wire logic hit_ctrl  = (wb_adr_i == `DD_A_CTRL);
  wire logic hit_count = (wb_adr_i == `DD_A_COUNT);

  // read selection
  logic [31:0] rd_mux;
  always_comb
  begin
    unique case (wb_adr_i)
      `DD_A_CTRL:    rd_mux = {31'h00000000, ctrl_en_ff};
      `DD_A_STATUS:  rd_mux = {27'h0000000, busy, test_sync_ff, irq_masked_ff, page_ff, arp_ff};
      `DD_A_LAST_OP: rd_mux = {13'h0000, op_taken_ff, op_target_ff, 1'b0, op_code_ff};
      `DD_A_COUNT:   rd_mux = {16'h0000, count_ff};
      default:       rd_mux = 32'h00000000;
    endcase
  end

  // ack, read data and control write
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ack_ff     <= 1'b0;
      dat_ff     <= 32'h00000000;
      ctrl_en_ff <= `DD_RST_ENABLE;
    end
    else
    begin
      ack_ff <= req;
      if (req)
        dat_ff <= rd_mux;
      if (wr_req && hit_ctrl && wb_sel_i[0])
        ctrl_en_ff <= wb_dat_i[0];
    end
  end

  // completed instructions; a completion in the clearing cycle still counts
  always_ff @(posedge clock)
  begin
    if (rst)
      count_ff <= 16'h0000;
    else if (wr_req && hit_count && (wb_sel_i[1:0] != 2'b00))
      count_ff <= {15'h0000, done_now};
    else if (done_now)
      count_ff <= count_ff + 16'h0001;
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

endmodule : dspdec_decoder

// ==== test/dspdec_fetch_model.sv ====
// dspdec_fetch_model: program fetch side of the decoder
// assumes decoder takes a word on a rising edge with valid and ready high
`timescale 1ns/1ps
module dspdec_fetch_model (
  input  wire logic        clock,
  input  wire logic        instr_ready,
  output logic             instr_valid,
  output logic      [15:0] instr_word
);
  // released lines show the inverse word, never a stale copy
  initial
  begin
    instr_valid = 1'b0;
    instr_word  = 16'hFFFF;
  end

  // offer one word, hold it while refused; more keeps valid up
  task automatic send(input logic [15:0] w, input logic more);
    instr_valid <= 1'b1;
    instr_word  <= w;
    @(posedge clock);
    while (instr_ready !== 1'b1)
      @(posedge clock);
    if (!more)
    begin
      instr_valid <= 1'b0;
      instr_word  <= ~w;
    end
  endtask : send
endmodule : dspdec_fetch_model

// ==== test/dspdec_chk.sv ====
// dspdec_chk: port assertions for the opcode decoder
// assumes one clock domain, rst synchronous and active high
`timescale 1ns/1ps
module dspdec_chk
  import dspdec_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic        instr_ready,
  input wire logic        acc_zero,
  input wire logic        acc_neg,
  input wire logic        aux_nonzero,
  input wire logic        ovf_flag,
  input wire logic        op_valid,
  input wire dspdec_op_e  op_code,
  input wire logic        op_taken,
  input wire logic [11:0] op_target,
  input wire logic        op_aux_sel,
  input wire logic        irq_masked,
  input wire logic        busy
);
  logic [15:0] first_ff;
  logic [15:0] last_word_ff;
  wire         take = instr_valid && instr_ready;

  // first word kept so the second-word edge knows the branch kind
  // last word kept one cycle, instead of property locals that free tools refuse
  always_ff @(posedge clock)
  begin
    last_word_ff <= instr_word;
    if (take && !busy)
      first_ff <= instr_word;
  end

  // branch outcome from the conditions seen at the second-word edge
  function automatic logic cond_f(input logic [7:0] b, input logic z, input logic n, input logic a,
                                  input logic v);
    case (b)
      8'hF4: return a;
      8'hF5: return v;
      8'hFA: return n;
      8'hFB: return n || z;
      8'hFC: return !n && !z;
      8'hFD: return !n;
      8'hFE: return !z;
      8'hFF: return z;
      default: return 1'b1;
    endcase
  endfunction : cond_f

  ////////////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge clock); endclocking
  default disable iff (rst);

  property p_ack_pulse;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("bus ack is not a single pulse");

  property p_unmapped;
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && !(wb_adr_i inside {8'h00, 8'h04, 8'h08, 8'h0C})
      |=> wb_dat_o == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_first_hold;
    take && !busy && instr_word[15:8] inside {[8'hF4:8'hF6], [8'hF8:8'hFF]} && instr_word[7:0] == 8'h00
      |=> busy && instr_ready && !op_valid;
  endproperty
  a_first_hold: assert property (p_first_hold) else $error("two-word op did not wait");

  property p_word2_done;
    busy && take |=> op_valid && !busy && op_target == last_word_ff[11:0];
  endproperty
  a_word2_done: assert property (p_word2_done) else $error("second word not completed");

  property p_two_cycle;
    take && !busy && (instr_word inside {16'h7F9C, 16'h7F9D, 16'h7F8C, 16'h7F8D} || instr_word[15:12] == 4'h4)
      |=> busy && !instr_ready ##1 op_valid && !busy;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("two-cycle op timing");

  property p_one_cycle;
    take && !busy && instr_word == 16'h7F8F |=> op_valid && op_code == DD_OP_ADD_PRODUCT && !busy;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("product add timing");

  property p_cond;
    busy && take && first_ff[15:8] != 8'hF6
      |=> op_taken == cond_f(first_ff[15:8], $past(acc_zero), $past(acc_neg), $past(aux_nonzero), $past(ovf_flag));
  endproperty
  a_cond: assert property (p_cond) else $error("branch outcome wrong");

  property p_aux_sel;
    take && !busy && instr_word[15:9] == 7'h38
      |=> op_valid && op_code == DD_OP_AUX_LOAD_IMM && op_aux_sel == last_word_ff[8];
  endproperty
  a_aux_sel: assert property (p_aux_sel) else $error("aux select bit wrong");

  property p_irq_mask;
    op_valid && op_code == DD_OP_IRQ_MASK |-> ##[0:1] irq_masked;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupts not masked");

  c_word2: cover property (busy && take);
  c_stall: cover property (busy && !instr_ready);
  c_read: cover property (wb_ack_o && !wb_we_i);
endmodule : dspdec_chk

bind dspdec_decoder dspdec_chk i_chk (.clock, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .instr_valid, .instr_word, .instr_ready, .acc_zero, .acc_neg, .aux_nonzero, .ovf_flag,
  .op_valid, .op_code, .op_taken, .op_target, .op_aux_sel, .irq_masked, .busy);

// ==== test/test_dsp_opcode_decoder.sv ====
// test_dsp_opcode_decoder: self-checking bench for the opcode decoder
// assumes fetch model and bound checker; 100 MHz clock
`timescale 1ns/1ps
module test_dsp_opcode_decoder;
  import dspdec_pkg::*;
  logic        clock = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o, rd;
  logic        acc_zero = 1'b0, acc_neg = 1'b0, aux_nonzero = 1'b0, ovf_flag = 1'b0;
  logic        test_pin = 1'b1, page_load_bit = 1'b0, wb_ack_o, instr_valid, instr_ready;
  logic        op_valid, op_taken, op_indirect, op_aux_sel, aux_select_pointer, page_pointer, irq_masked, busy;
  logic [15:0] instr_word;
  logic [11:0] op_target;
  logic [7:0]  op_operand;
  logic [6:0]  op_dma;
  logic [2:0]  op_port;
  dspdec_op_e  op_code;
  int          fails = 0, tests_run = 0, seed = 50196, done_n = 0;
  // opcode base and free operand bits, in op code order
  logic [15:0] base_t [30] = '{16'h7F80, 16'hF900, 16'hF400, 16'hFD00, 16'hFC00, 16'hFB00, 16'hFA00,
    16'hFE00, 16'hFF00, 16'hF600, 16'hF500, 16'h7F8C, 16'hF800, 16'h7F8D, 16'h7F81, 16'h7F82, 16'h7B00,
    16'h7F9D, 16'h7F9C, 16'h6900, 16'h4000, 16'h4800, 16'h7F8F, 16'h6B00, 16'h7000, 16'h6880, 16'h6F00,
    16'h6E00, 16'h6800, 16'h3000};
  logic [15:0] free_t [30] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h00FF,
    16'h0000, 16'h0000, 16'h00FF, 16'h07FF, 16'h07FF, 16'h0000, 16'h00FF, 16'h01FF, 16'h0001, 16'h00FF,
    16'h0001, 16'h007F, 16'h01FF};

  always #5 clock = ~clock;

  dspdec_decoder i_dut (.clock, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .instr_valid, .instr_word, .instr_ready, .acc_zero, .acc_neg, .aux_nonzero,
    .ovf_flag, .test_pin, .page_load_bit, .op_valid, .op_code, .op_taken, .op_target, .op_dma, .op_indirect,
    .op_operand, .op_aux_sel, .op_port, .aux_select_pointer, .page_pointer, .irq_masked, .busy);
  dspdec_fetch_model i_fetch (.clock, .instr_ready, .instr_valid, .instr_word);

  // completions seen by the bench, to check the count register
  always @(posedge clock)
    if (rst === 1'b0 && op_valid === 1'b1)
      done_n++;

  ////////////////////////////////////////////////////////////////////////////
  function automatic int words_f(input int i);
    return (i >= 1 && i <= 12 && i != 11) ? 2 : 1;
  endfunction : words_f

  function automatic int lat_f(input int i);
    return (i inside {11, 13, 17, 18, 20, 21}) ? 2 : 1;
  endfunction : lat_f

  function automatic logic taken_f(input int i);
    case (i)
      1, 12: return 1'b1;
      2: return aux_nonzero;
      3: return !acc_neg;
      4: return !acc_neg && !acc_zero;
      5: return acc_neg || acc_zero;
      6: return acc_neg;
      7: return !acc_zero;
      8: return acc_zero;
      9: return !test_pin;
      10: return ovf_flag;
      default: return 1'b0;
    endcase
  endfunction : taken_f

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // classic single wishbone cycle; only the watchdog ends a lost ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    @(posedge clock);
    while (wb_ack_o !== 1'b1)
      @(posedge clock);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask : wb

  // one instruction with random operand and conditions
  task automatic run(input int i);
    logic [15:0] w, t;
    logic [5:0]  r;
    int          n;
    w = base_t[i] | (16'($random(seed)) & free_t[i]);
    t = 16'($random(seed));
    r = 6'($random(seed));
    acc_zero <= r[0];
    acc_neg <= r[1] & !r[0];
    aux_nonzero <= r[2];
    ovf_flag <= r[3];
    test_pin <= r[4];
    page_load_bit <= r[5];
    repeat (3) @(posedge clock); // test pin synchroniser settles
    i_fetch.send(w, words_f(i) == 2);
    if (words_f(i) == 2)
      i_fetch.send(t, 1'b0);
    n = 1;
    @(posedge clock);
    while (op_valid !== 1'b1 && n < 9)
    begin
      @(posedge clock);
      n++;
    end
    chk(n, lat_f(i));
    chk(op_code, 32'(i));
    chk(op_taken, taken_f(i));
    chk(op_target, words_f(i) == 2 ? t[11:0] : 12'h000);
    chk({op_indirect, op_dma, op_port, op_aux_sel}, {w[7:0], w[10:8], w[8]});
    chk(op_operand, w[7:0]);
    @(posedge clock);
    if (i == 14 || i == 15)
      chk(irq_masked, i == 14);
    if (i == 25)
      chk(aux_select_pointer, w[0]);
    if (i == 26 || i == 27)
      chk(page_pointer, i == 27 ? w[0] : page_load_bit);
  endtask : run

  task automatic conclude;
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk({busy, irq_masked, aux_select_pointer, page_pointer, instr_ready}, 5'b01001);
    wb(1'b0, 8'h00, 32'h00000000, rd);
    chk(rd, 32'h00000001);
    wb(1'b1, 8'h00, 32'h00000000, rd);
    chk(instr_ready, 1'b0);
    wb(1'b1, 8'h00, 32'h00000001, rd);
    for (int p = 0; p < 4; p++)
      for (int i = 0; i < 30; i++)
        run(i);
    i_fetch.send(16'hF900, 1'b1);
    i_fetch.send(16'h0ABC, 1'b1);
    i_fetch.send(16'h7F9C, 1'b0);
    chk({op_valid, op_target}, {1'b1, 12'hABC});
    repeat (2) @(posedge clock);
    chk({op_valid, op_code}, {1'b1, DD_OP_STACK_PUSH});
    @(posedge clock);
    wb(1'b0, 8'h08, 32'h00000000, rd);
    chk(rd, 32'h00000012);
    wb(1'b0, 8'h0C, 32'h00000000, rd);
    chk(rd, {16'h0000, 16'(done_n)});
    wb(1'b1, 8'h0C, 32'h00000000, rd);
    wb(1'b0, 8'h0C, 32'h00000000, rd);
    chk(rd, 32'h00000000);
    run(14);
    wb(1'b0, 8'h04, 32'h00000000, rd);
    chk(rd[2], 1'b1);
    run(15);
    wb(1'b1, 8'h20, 32'h00000000, rd);
    wb(1'b0, 8'h10, 32'h00000000, rd);
    chk(rd, 32'h00000000);
    wb(1'b0, 8'h04, 32'h00000000, rd);
    chk(rd[2], 1'b0);
    wb(1'b0, 8'h00, 32'h00000000, rd);
    chk(rd, 32'h00000001);
    conclude();
  end

  // about 124 instructions of under 30 cycles each; wide margin
  initial
  begin
    #300000;
    fails++;
    conclude();
  end
endmodule : test_dsp_opcode_decoder
